// *** verilog/ecp_port.sv ***
// external control port logic: pin sync, decode, alarm latch, contacts
`timescale 1ns/1ps
module ecp_port #(
  parameter int RESUME_CYCLES = ecp_pkg::RESUME_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire ecp_pkg::ecp_pins_t pins,
  input wire logic load_active_high,
  input wire logic [ecp_pkg::NUM_FAULTS-1:0] protect_fault,
  input wire logic seq_paused,
  output logic load_on_ff,
  output logic range_60v_ff,
  output ecp_pkg::ecp_mode_t mode_ff,
  output logic [2:0] recall_pulse_ff,
  output logic resume_pulse_ff,
  output logic alarm_ff,
  output ecp_pkg::ecp_contacts_t contacts_ff
);
  // the pulse compare needs a bound minus one that is above zero
  if (RESUME_CYCLES < 2) begin : g_bad_resume
    $error("RESUME_CYCLES too small");
  end
  localparam int NUM_SLOTS = 3;
  localparam int CW = $clog2(RESUME_CYCLES + 1);
  localparam logic [CW-1:0] RES_MAX = CW'(RESUME_CYCLES);
  // =========================================================
  // two-stage synchroniser, idle high so pins read inactive, except the load switch when load_active_high is set
  logic [ecp_pkg::PIN_W-1:0] meta_ff;
  logic [ecp_pkg::PIN_W-1:0] sync_ff;
  ecp_pkg::ecp_pins_t s;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= pins;
      sync_ff <= meta_ff;
    end
  end
  assign s = sync_ff;
  // =========================================================
  // load switch, polarity selectable
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      load_on_ff <= 1'b0;
    end else begin
      load_on_ff <= load_active_high ? s.load_switch_in : !s.load_switch_in;
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      range_60v_ff <= 1'b0;
    end else begin
      range_60v_ff <= !s.range_select_in;
    end
  end
  // =========================================================
  // regulation mode decode
  logic [2:0] sel;
  ecp_pkg::ecp_mode_t nxt_mode;
  assign sel = {s.regulation_sel_bit2, s.regulation_sel_bit1, s.regulation_sel_bit0};
  always_comb begin
    case (sel)
      ecp_pkg::SEL_CURRENT: nxt_mode = ecp_pkg::ECP_MODE_CURRENT;
      ecp_pkg::SEL_RESIST: nxt_mode = ecp_pkg::ECP_MODE_RESIST;
      ecp_pkg::SEL_POWER: nxt_mode = ecp_pkg::ECP_MODE_POWER;
      ecp_pkg::SEL_VOLTAGE: nxt_mode = ecp_pkg::ECP_MODE_VOLTAGE;
      ecp_pkg::SEL_CUR_VOLT: nxt_mode = ecp_pkg::ECP_MODE_CUR_VOLT;
      ecp_pkg::SEL_RES_VOLT: nxt_mode = ecp_pkg::ECP_MODE_RES_VOLT;
      default: nxt_mode = ecp_pkg::ECP_MODE_NONE;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mode_ff <= ecp_pkg::ECP_MODE_NONE;
    end else begin
      mode_ff <= nxt_mode;
    end
  end
  // =========================================================
  // preset recall: one pulse on each falling edge
  logic [NUM_SLOTS-1:0] rec_low;
  logic [NUM_SLOTS-1:0] rec_prev_ff;
  assign rec_low = ~{s.recall_slot_c_in, s.recall_slot_b_in, s.recall_slot_a_in};
  // previous level resets to idle so no false edge follows reset
  for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_recall
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        rec_prev_ff[g] <= 1'b0;
        recall_pulse_ff[g] <= 1'b0;
      end else begin
        rec_prev_ff[g] <= rec_low[g];
        recall_pulse_ff[g] <= rec_low[g] & ~rec_prev_ff[g];
      end
    end
  end
  // =========================================================
  // resume: count low time, fire once per hold while paused
  logic [CW-1:0] res_cnt_ff;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      res_cnt_ff <= '0;
    end else if (s.resume_in) begin
      res_cnt_ff <= '0;
    end else if (res_cnt_ff != RES_MAX) begin
      res_cnt_ff <= res_cnt_ff + CW'(1);
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      resume_pulse_ff <= 1'b0;
    end else begin
      // fires on reaching the bound; a pause entered later needs a new hold
      resume_pulse_ff <= seq_paused && !s.resume_in && (res_cnt_ff == RES_MAX - CW'(1));
    end
  end
  // =========================================================
  // alarm latch: set wins over clear
  logic cause;
  assign cause = (|protect_fault) || !s.external_fault_in;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_ff <= 1'b0;
    end else if (cause) begin
      alarm_ff <= 1'b1;
    end else if (!s.fault_clear_in) begin
      alarm_ff <= 1'b0;
    end
  end
  // =========================================================
  // relay contacts
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      contacts_ff <= '0;
    end else begin
      contacts_ff.load_active <= load_on_ff;
      contacts_ff.fault_active <= alarm_ff;
      contacts_ff.low_range <= !range_60v_ff;
    end
  end
  // =========================================================
  // checks: alarm, load and range

  ext_fault_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !s.external_fault_in
    |=> alarm_ff)
    else $error("external fault did not raise alarm");

  protect_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (|protect_fault)
    |=> alarm_ff)
    else $error("protection fault did not raise alarm");

  load_pol_a: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1
    |=> load_on_ff == ($past(load_active_high) ? $past(s.load_switch_in)
    : !$past(s.load_switch_in)))
    else $error("load state wrong for polarity");

  range_sel_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !s.range_select_in
    |=> range_60v_ff)
    else $error("60 V range not selected");

  range_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
    s.range_select_in
    |=> !range_60v_ff)
    else $error("60 V range held without select");

  // =========================================================
  // checks: regulation decode

  mode_current_a: assert property (@(posedge mclk) disable iff (!rst_b)
    sel == ecp_pkg::SEL_CURRENT
    |=> mode_ff == ecp_pkg::ECP_MODE_CURRENT)
    else $error("current mode decode");

  mode_resist_a: assert property (@(posedge mclk) disable iff (!rst_b)
    sel == ecp_pkg::SEL_RESIST
    |=> mode_ff == ecp_pkg::ECP_MODE_RESIST)
    else $error("resistance mode decode");

  mode_power_a: assert property (@(posedge mclk) disable iff (!rst_b)
    sel == ecp_pkg::SEL_POWER
    |=> mode_ff == ecp_pkg::ECP_MODE_POWER)
    else $error("power mode decode");

  mode_voltage_a: assert property (@(posedge mclk) disable iff (!rst_b)
    sel == ecp_pkg::SEL_VOLTAGE
    |=> mode_ff == ecp_pkg::ECP_MODE_VOLTAGE)
    else $error("voltage mode decode");

  mode_cur_volt_a: assert property (@(posedge mclk) disable iff (!rst_b)
    sel == ecp_pkg::SEL_CUR_VOLT
    |=> mode_ff == ecp_pkg::ECP_MODE_CUR_VOLT)
    else $error("current plus voltage decode");

  mode_res_volt_a: assert property (@(posedge mclk) disable iff (!rst_b)
    sel == ecp_pkg::SEL_RES_VOLT
    |=> mode_ff == ecp_pkg::ECP_MODE_RES_VOLT)
    else $error("resistance plus voltage decode");

  mode_none_a: assert property (@(posedge mclk) disable iff (!rst_b)
    sel == '0 || sel == '1
    |=> mode_ff == ecp_pkg::ECP_MODE_NONE)
    else $error("unlisted code gave a mode");

  // =========================================================
  // checks: recall and resume

  recall_edge_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(s.recall_slot_a_in)
    |=> recall_pulse_ff[0])
    else $error("recall a missed");

  recall_b_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(s.recall_slot_b_in)
    |=> recall_pulse_ff[1])
    else $error("recall b missed");

  recall_c_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(s.recall_slot_c_in)
    |=> recall_pulse_ff[2])
    else $error("recall c missed");

  recall_once_a: assert property (@(posedge mclk) disable iff (!rst_b)
    recall_pulse_ff[0]
    |=> !recall_pulse_ff[0])
    else $error("recall pulse longer than one cycle");

  resume_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    resume_pulse_ff
    |-> $past(res_cnt_ff) == RES_MAX - CW'(1) && $past(seq_paused))
    else $error("resume without full hold");

  resume_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !seq_paused
    |=> !resume_pulse_ff)
    else $error("resume while not paused");

  resume_once_a: assert property (@(posedge mclk) disable iff (!rst_b)
    resume_pulse_ff
    |=> !resume_pulse_ff)
    else $error("resume pulse longer than one cycle");

  res_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
    s.resume_in
    |=> res_cnt_ff == '0)
    else $error("hold count not cleared");

  res_bound_a: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1
    |-> res_cnt_ff <= RES_MAX)
    else $error("hold count past bound");

  // =========================================================
  // checks: clear, contacts, sync

  clear_guard_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(alarm_ff)
    |-> !$past(cause) && !$past(s.fault_clear_in))
    else $error("alarm cleared with cause present");

  alarm_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    alarm_ff && s.fault_clear_in
    |=> alarm_ff)
    else $error("alarm dropped without clear");

  load_contact_a: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1
    |=> contacts_ff.load_active == $past(load_on_ff))
    else $error("load contact");

  fault_contact_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (|protect_fault)
    |=> ##1 contacts_ff.fault_active)
    else $error("fault contact");

  ext_contact_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !s.external_fault_in
    |=> ##1 contacts_ff.fault_active)
    else $error("fault contact on external alarm");

  range_contact_a: assert property (@(posedge mclk) disable iff (!rst_b)
    s.range_select_in
    |=> ##1 contacts_ff.low_range)
    else $error("low range contact");

  range_open_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !s.range_select_in
    |=> ##1 !contacts_ff.low_range)
    else $error("low range contact made in 60 V range");

  meta_path_a: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1
    |=> meta_ff == $past(pins))
    else $error("first sync stage broken");

  sync_path_a: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1
    |=> sync_ff == $past(meta_ff))
    else $error("sync chain broken");

  resume_c: cover property (@(posedge mclk) disable iff (!rst_b) resume_pulse_ff);
  load_c: cover property (@(posedge mclk) disable iff (!rst_b) contacts_ff.load_active);
  clear_c: cover property (@(posedge mclk) disable iff (!rst_b) $fell(alarm_ff));
  recall_c: cover property (@(posedge mclk) disable iff (!rst_b) recall_pulse_ff[2]);
  mode_c: cover property (@(posedge mclk) disable iff (!rst_b) mode_ff == ecp_pkg::ECP_MODE_POWER);
endmodule

// *** verilog/ecp_pkg.sv ***
// constants and types for the external control port logic
// Operation
// - a low on the external fault input raises the alarm condition.
// - load switches on when its input reaches the selected active level, low or high.
// - range select input held low selects the 60 V range.
// - three regulation select bits decode to six current, resistance, power, voltage modes.
// - a low on a recall input recalls preset memory A, B or C.
// - while paused, resume input low for 100 ms or longer releases the pause.
// - fault clear low clears the alarm only once every cause has gone.
// - load-active contact closes while load is on, opens when off.
// - fault contact closes while any protection alarm or external alarm is active.
// - low-range contact closes while the 30 V range is selected.
package ecp_pkg;
  // =========================================================
  // timing
  localparam int CLK_HZ = 50000000;
  localparam int RESUME_MS = 100;
  localparam int RESUME_CYCLES = (CLK_HZ / 1000) * RESUME_MS;
  localparam int NUM_FAULTS = 8;
  // =========================================================
  // regulation modes, code is {bit2, bit1, bit0}
  typedef enum logic [2:0] {
    ECP_MODE_NONE = 3'h0,
    ECP_MODE_CURRENT = 3'h1,
    ECP_MODE_RESIST = 3'h2,
    ECP_MODE_POWER = 3'h3,
    ECP_MODE_VOLTAGE = 3'h4,
    ECP_MODE_CUR_VOLT = 3'h5,
    ECP_MODE_RES_VOLT = 3'h6
  } ecp_mode_t;
  localparam logic [2:0] SEL_CURRENT = 3'h3;
  localparam logic [2:0] SEL_RESIST = 3'h5;
  localparam logic [2:0] SEL_POWER = 3'h1;
  localparam logic [2:0] SEL_VOLTAGE = 3'h6;
  localparam logic [2:0] SEL_CUR_VOLT = 3'h2;
  localparam logic [2:0] SEL_RES_VOLT = 3'h4;
  // =========================================================
  // raw pin group, all levels as seen on the connector
  typedef struct packed {
    logic external_fault_in;
    logic load_switch_in;
    logic range_select_in;
    logic regulation_sel_bit2;
    logic regulation_sel_bit1;
    logic regulation_sel_bit0;
    logic recall_slot_c_in;
    logic recall_slot_b_in;
    logic recall_slot_a_in;
    logic resume_in;
    logic fault_clear_in;
  } ecp_pins_t;
  localparam int PIN_W = 11;
  // status contacts, 1 means contact made
  typedef struct packed {
    logic load_active;
    logic fault_active;
    logic low_range;
  } ecp_contacts_t;
endpackage

// *** sim/ecp_ctrl_model.sv ***
// external controller model driving the connector control lines
`timescale 1ns/1ps
module ecp_ctrl_model (
  input wire logic mclk,
  output ecp_pkg::ecp_pins_t pins
);
  // lines idle high, every control except the polarity-selectable load switch is active low
  initial pins = '1;
  // change lines just after an edge, then hold them n edges
  task automatic put(input ecp_pkg::ecp_pins_t v, input int n);
    @(posedge mclk);
    pins <= v;
    repeat (n) @(posedge mclk);
  endtask
endmodule

// *** sim/ecp_port_test.sv ***
// self-checking bench for the external control port logic
`timescale 1ns/1ps
module ecp_port_test;
  localparam int RC = 20;
  localparam logic [17:0] CODES = {3'h4, 3'h2, 3'h6, 3'h1, 3'h5, 3'h3};
  logic mclk = 0, rst_b = 0, load_active_high = 0, seq_paused = 0;
  logic [7:0] protect_fault = '0;
  ecp_pkg::ecp_pins_t pins, p;
  logic load_on_ff, range_60v_ff, resume_pulse_ff, alarm_ff;
  ecp_pkg::ecp_mode_t mode_ff;
  logic [2:0] recall_pulse_ff;
  logic [3:0] s;
  ecp_pkg::ecp_contacts_t contacts_ff;
  int n_errors = 0, n_tests = 0;
  always #10 mclk = ~mclk;
  ecp_ctrl_model ctrl (.mclk(mclk), .pins(pins));
  ecp_port #(.RESUME_CYCLES(RC)) uut (.mclk(mclk), .rst_b(rst_b), .pins(pins),
    .load_active_high(load_active_high), .protect_fault(protect_fault),
    .seq_paused(seq_paused), .load_on_ff(load_on_ff), .range_60v_ff(range_60v_ff),
    .mode_ff(mode_ff), .recall_pulse_ff(recall_pulse_ff),
    .resume_pulse_ff(resume_pulse_ff), .alarm_ff(alarm_ff), .contacts_ff(contacts_ff));
  // ==========================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // five edges covers sync, decode and contact stages
  task automatic drv(input ecp_pkg::ecp_pins_t v);
    ctrl.put(v, 5);
    // step off the edge so outputs are read settled
    #1;
  endtask
  // bounded watch, pulses gathered into s
  task automatic watch(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1 s = s | {resume_pulse_ff, recall_pulse_ff};
    end
  endtask
  task automatic finish_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_load();
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      load_active_high <= i[0];
      p = '1;
      p.load_switch_in = i[0];
      drv(p);
      chk("load_on", 1, load_on_ff);
      chk("load contact", 1, contacts_ff.load_active);
      p.load_switch_in = ~i[0];
      drv(p);
      chk("load_off", 0, load_on_ff);
      chk("load contact", 0, contacts_ff.load_active);
    end
    $display("t_load done");
  endtask
  task automatic t_range();
    p = '1;
    p.range_select_in = 0;
    drv(p);
    chk("range 60", 1, range_60v_ff);
    chk("low contact", 0, contacts_ff.low_range);
    drv('1);
    chk("range 30", 0, range_60v_ff);
    chk("low contact", 1, contacts_ff.low_range);
    $display("t_range done");
  endtask
  task automatic t_mode();
    for (int i = 0; i < 7; i++) begin
      p = '1;
      if (i < 6) {p.regulation_sel_bit2, p.regulation_sel_bit1,
        p.regulation_sel_bit0} = CODES[3*i +: 3];
      drv(p);
      chk("mode", (i < 6) ? i + 1 : 0, mode_ff);
    end
    $display("t_mode done");
  endtask
  task automatic t_recall();
    for (int i = 0; i < 3; i++) begin
      p = '1;
      p[2+i] = 0;
      s = '0;
      ctrl.put(p, 0);
      watch(8);
      chk("recall", 4'h1 << i, s);
      drv('1);
    end
    $display("t_recall done");
  endtask
  // short paused hold, long unpaused hold, long paused hold
  task automatic t_resume();
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      seq_paused <= (i != 1);
      p = '1;
      p.resume_in = 0;
      s = '0;
      ctrl.put(p, 0);
      watch((i == 0) ? RC / 2 : RC + 6);
      ctrl.put('1, 0);
      watch(8);
      chk("resume", (i == 2) ? 4'h8 : 4'h0, s);
    end
    $display("t_resume done");
  endtask
  task automatic t_alarm();
    p = '1;
    p.external_fault_in = 0;
    drv(p);
    chk("alarm", 1, alarm_ff);
    chk("fault contact", 1, contacts_ff.fault_active);
    @(posedge mclk);
    protect_fault <= 8'h01;
    p = '1;
    p.fault_clear_in = 0;
    drv(p);
    chk("alarm held", 1, alarm_ff);
    @(posedge mclk);
    protect_fault <= '0;
    drv(p);
    chk("alarm clear", 0, alarm_ff);
    chk("fault contact", 0, contacts_ff.fault_active);
    drv('1);
    $display("t_alarm done");
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1;
    t_load();
    t_range();
    t_mode();
    t_recall();
    t_resume();
    t_alarm();
    finish_test();
  end
endmodule
